// [hdl/codec_params.svh]
// Purpose : constants for the lane 8b/10b codec
// Assumes : code-groups are held as {a,b,c,d,e,i,f,g,h,j}, a in bit 9
// Notes   : six-bit and four-bit data tables hold the negative-column values; the K28 four-bit table holds the positive-column values
`ifndef CODEC_PARAMS_SVH
`define CODEC_PARAMS_SVH

// ==========================================================================
// character fields
`define CODEC_X_K28        5'h1C
`define CODEC_Y_ALT        3'h7

// ==========================================================================
// sub-block patterns and balance counts
`define CODEC_K28_6B       6'h0F
`define CODEC_6B_POS_BAL   6'h07
`define CODEC_6B_NEG_BAL   6'h38
`define CODEC_4B_POS_BAL   4'h3
`define CODEC_4B_NEG_BAL   4'hC
`define CODEC_4B_ALT       4'h7
`define CODEC_6B_ONES      3
`define CODEC_4B_ONES      2
`define CODEC_CG_ONES      5

// ==========================================================================
// encoding tables, entry 0 in the low bits
`define CODEC_LUT6 {6'h2B, 6'h1E, 6'h2E, 6'h0E, 6'h36, 6'h16, 6'h26, \
  6'h33, 6'h3A, 6'h1A, 6'h2A, 6'h0B, 6'h32, 6'h13, 6'h23, 6'h1B, \
  6'h17, 6'h1C, 6'h2C, 6'h0D, 6'h34, 6'h15, 6'h25, 6'h39, 6'h38, \
  6'h19, 6'h29, 6'h35, 6'h31, 6'h2D, 6'h1D, 6'h27}
`define CODEC_LUT4 {4'hE, 4'h6, 4'hA, 4'hD, 4'hC, 4'h5, 4'h9, 4'hB}
`define CODEC_K28_4B {4'h7, 4'h9, 4'h5, 4'hD, 4'hC, 4'hA, 4'h6, 4'hB}
`define CODEC_K7_MASK      32'h6880_0000
`define CODEC_ALT_NEG_MASK 32'h0016_0000
`define CODEC_ALT_POS_MASK 32'h0000_6800

// ==========================================================================
// reference characters
`define CODEC_D07_BYTE     8'h07
`define CODEC_D07_NEG      10'h38B
`define CODEC_D07_POS      10'h074
`define CODEC_D35_BYTE     8'h23
`define CODEC_D35_CODE     10'h319

`endif

// [hdl/codec_pkg.sv]
// Purpose : types for the lane 8b/10b codec
// Assumes : one lane, one character clock
// Notes   : none
package codec_pkg;

  // ========================================================================
  // running disparity and lane state
  typedef enum logic {RD_NEG, RD_POS} rd_type;

  typedef struct packed {
    rd_type     tx_rd;
    rd_type     rx_rd;
    logic       rx_valid;
    logic [7:0] rx_byte;
    logic       rx_special;
    logic       rx_invalid;
  } lane_state_type;

endpackage

// [hdl/lane_8b10b_codec.sv]
// Purpose : one lane of 8b/10b coding, transmit encoder and receive decoder
// Assumes : code-group bit 9 is a and bit 0 is j; receive code-groups arrive
//           word-aligned from logic on clk_sys_i
// Notes   : transmit code-groups pass a two-entry buffer toward the serdes
// Contract
// R1 - encoder disparity starts negative after reset
// R2 - decoder start disparity is a reset parameter
// R3 - disparity follows each lane's own code-groups
// R4 - six-bit block then four-bit block chain
// R5 - more ones or 000111/0011 gives positive
// R6 - more zeros or 111000/1100 gives negative
// R7 - otherwise sub-block keeps incoming disparity
// R8 - encode 256 data, 12 special characters
// R9 - encoder picks column by current disparity
// R10 - encoder updates disparity from emitted code-group
// R11 - bit a sent first, order abcdeifghj
// R12 - decoder outputs nine-bit character, flags undefined
// R13 - decoder searches both tables in column
// R14 - unmatched code-group yields invalid character
// R15 - decoder updates disparity after each code-group
// R16 - data 0x07 codes 111000 1011 / 000111 0100
// R17 - data 0x23 codes 110001 1001 both ways
// R18 - character is byte plus data/special flag
// R19 - x is low five bits, y high three
// R20 - separate encoder and decoder disparity state
// R21 - one item per cycle when valid, else hold
// R22 - decoder updates disparity even on invalid
`timescale 1ns/100ps
`include "codec_params.svh"

module lane_8b10b_codec #(
  parameter codec_pkg::rd_type RX_INIT_RD = codec_pkg::RD_NEG
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        tx_char_valid_i,
  input  wire logic [7:0]  tx_byte_i,
  input  wire logic        tx_special_i,
  output logic             tx_char_ready_o,
  output logic             tx_code_valid_o,
  output logic [9:0]       tx_code_o,
  input  wire logic        tx_code_ready_i,
  output codec_pkg::rd_type tx_disparity_o,
  input  wire logic        rx_code_valid_i,
  input  wire logic [9:0]  rx_code_i,
  output logic             rx_char_valid_o,
  output logic [7:0]       rx_byte_o,
  output logic             rx_special_o,
  output logic             rx_invalid_o,
  output codec_pkg::rd_type rx_disparity_o
);
  import codec_pkg::*;

  localparam logic [191:0] LUT6     = `CODEC_LUT6;
  localparam logic [31:0]  LUT4     = `CODEC_LUT4;
  localparam logic [31:0]  K28_4    = `CODEC_K28_4B;
  localparam logic [31:0]  K7       = `CODEC_K7_MASK;
  localparam logic [31:0]  ALT_NEG  = `CODEC_ALT_NEG_MASK;
  localparam logic [31:0]  ALT_POS  = `CODEC_ALT_POS_MASK;

  lane_state_type st_ff;
  lane_state_type nxt_st;

  // ==========================================================================
  // sub-block encoders
  function automatic logic [5:0] enc6(input logic [4:0] x,
                                      input logic       k,
                                      input rd_type     rd);
    logic [5:0] base;
    base = (k && x == `CODEC_X_K28) ? `CODEC_K28_6B : LUT6[x * 6 +: 6];
    if (rd == RD_POS && ($countones(base) != `CODEC_6B_ONES ||
                         base == `CODEC_6B_NEG_BAL)) begin
      enc6 = ~base; // [R9]
    end else begin
      enc6 = base;
    end
  endfunction

  function automatic logic [3:0] enc4(input logic [2:0] y,
                                      input logic [4:0] x,
                                      input logic       k,
                                      input rd_type     rd4);
    logic       k28;
    logic       alt;
    logic [3:0] base;
    k28 = k && x == `CODEC_X_K28;
    alt = y == `CODEC_Y_ALT && (k || (rd4 == RD_NEG && ALT_NEG[x]) ||
                                (rd4 == RD_POS && ALT_POS[x]));
    if (k28) begin
      base = K28_4[y * 4 +: 4];
    end else if (alt) begin
      base = `CODEC_4B_ALT;
    end else begin
      base = LUT4[y * 4 +: 4];
    end
    if (rd4 == RD_POS && ($countones(base) != `CODEC_4B_ONES ||
                          base == `CODEC_4B_NEG_BAL || k28)) begin
      enc4 = ~base; // [R4]
    end else begin
      enc4 = base;
    end
  endfunction

  // ==========================================================================
  // transmit encoder
  logic [4:0] tx_x;
  logic [2:0] tx_y;
  logic [5:0] tx_6b;
  logic [3:0] tx_4b;
  logic [9:0] tx_in_code;
  rd_type     tx_rd4;
  rd_type     tx_rd_end;
  logic       tx_take;

  assign tx_x       = tx_byte_i[4:0]; // [R19]
  assign tx_y       = tx_byte_i[7:5]; // [R19]
  assign tx_6b      = enc6(tx_x, tx_special_i, st_ff.tx_rd); // [R8] [R18]
  assign tx_4b      = enc4(tx_y, tx_x, tx_special_i, tx_rd4); // [R4] [R8]
  assign tx_in_code = {tx_6b, tx_4b}; // [R11]
  assign tx_take    = tx_char_valid_i && tx_char_ready_o; // [R21]

  sub_block_disparity #(
    .WIDTH   (6),
    .POS_PAT (`CODEC_6B_POS_BAL),
    .NEG_PAT (`CODEC_6B_NEG_BAL)
  ) u_tx_rd6 (
    .rd_i    (st_ff.tx_rd),
    .block_i (tx_6b),
    .rd_o    (tx_rd4)
  );

  sub_block_disparity #(
    .WIDTH   (4),
    .POS_PAT (`CODEC_4B_POS_BAL),
    .NEG_PAT (`CODEC_4B_NEG_BAL)
  ) u_tx_rd4 (
    .rd_i    (tx_rd4),
    .block_i (tx_4b),
    .rd_o    (tx_rd_end)
  );

  // holds the code-group while the serdes stalls
  tx_skid_buffer #(
    .WIDTH       (10)
  ) u_tx_buf (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .in_valid_i  (tx_char_valid_i),
    .in_data_i   (tx_in_code),
    .in_ready_o  (tx_char_ready_o),
    .out_valid_o (tx_code_valid_o),
    .out_data_o  (tx_code_o),
    .out_ready_i (tx_code_ready_i)
  );

  // ==========================================================================
  // receive decoder
  logic [5:0] rx_6b;
  logic [3:0] rx_4b;
  rd_type     rx_rd4;
  rd_type     rx_rd_end;
  logic       hit_d;
  logic       hit_k28;
  logic [4:0] x_d;
  logic       dec_hit;
  logic       dec_special;
  logic [7:0] dec_byte;

  assign rx_6b = rx_code_i[9:4];
  assign rx_4b = rx_code_i[3:0];

  // disparity comes from the received bits, matched or not
  sub_block_disparity #(
    .WIDTH   (6),
    .POS_PAT (`CODEC_6B_POS_BAL),
    .NEG_PAT (`CODEC_6B_NEG_BAL)
  ) u_rx_rd6 (
    .rd_i    (st_ff.rx_rd),
    .block_i (rx_6b),
    .rd_o    (rx_rd4)
  );

  sub_block_disparity #(
    .WIDTH   (4),
    .POS_PAT (`CODEC_4B_POS_BAL),
    .NEG_PAT (`CODEC_4B_NEG_BAL)
  ) u_rx_rd4 (
    .rd_i    (rx_rd4),
    .block_i (rx_4b),
    .rd_o    (rx_rd_end)
  );

  // search of the selected column, data and special tables
  always_comb begin
    hit_d = 1'b0;
    x_d   = '0;
    for (int i = 0; i < 32; i++) begin
      if (rx_6b == enc6(5'(i), 1'b0, st_ff.rx_rd)) begin // [R13]
        hit_d = 1'b1;
        x_d   = 5'(i);
      end
    end
    hit_k28     = rx_6b == enc6(`CODEC_X_K28, 1'b1, st_ff.rx_rd); // [R13]
    dec_hit     = 1'b0;
    dec_special = 1'b0;
    dec_byte    = '0;
    for (int j = 0; j < 8; j++) begin
      if (hit_d && rx_4b == enc4(3'(j), x_d, 1'b0, rx_rd4)) begin
        dec_hit  = 1'b1;
        dec_byte = {3'(j), x_d};
      end
      if (hit_k28 &&
          rx_4b == enc4(3'(j), `CODEC_X_K28, 1'b1, rx_rd4)) begin
        dec_hit     = 1'b1;
        dec_special = 1'b1;
        dec_byte    = {3'(j), `CODEC_X_K28};
      end
    end
    if (hit_d && K7[x_d] &&
        rx_4b == enc4(`CODEC_Y_ALT, x_d, 1'b1, rx_rd4)) begin
      dec_hit     = 1'b1;
      dec_special = 1'b1;
      dec_byte    = {`CODEC_Y_ALT, x_d};
    end
  end

  // ==========================================================================
  // lane state
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.rx_valid = rx_code_valid_i; // [R21]
    if (tx_take) begin
      nxt_st.tx_rd = tx_rd_end; // [R10] [R3] [R20]
    end
    if (rx_code_valid_i) begin
      nxt_st.rx_rd      = rx_rd_end; // [R15] [R22] [R20]
      nxt_st.rx_byte    = dec_byte; // [R12]
      nxt_st.rx_special = dec_special; // [R18]
      nxt_st.rx_invalid = !dec_hit; // [R14]
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '{tx_rd: RD_NEG, rx_rd: RX_INIT_RD, rx_valid: 1'b0,
                 rx_byte: '0, rx_special: 1'b0,
                 rx_invalid: 1'b0}; // [R1] [R2]
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tx_disparity_o  = st_ff.tx_rd;
  assign rx_disparity_o  = st_ff.rx_rd;
  assign rx_char_valid_o = st_ff.rx_valid;
  assign rx_byte_o       = st_ff.rx_byte;
  assign rx_special_o    = st_ff.rx_special;
  assign rx_invalid_o    = st_ff.rx_invalid;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_tx_take;
    tx_char_valid_i && tx_char_ready_o;
  endsequence

  sequence s_tx_stall;
    tx_code_valid_o && !tx_code_ready_i;
  endsequence

  sequence s_rx_take;
    rx_code_valid_i;
  endsequence

  a_enc_init_neg: assert property ( // [R1]
    $fell(rst_i) |-> tx_disparity_o == RD_NEG)
    else $error("encoder disparity not negative after reset");

  a_dec_init_rd: assert property ( // [R2]
    $fell(rst_i) |-> rx_disparity_o == RX_INIT_RD)
    else $error("decoder disparity not at its reset value");

  a_enc_rd_hold: assert property ( // [R21]
    !(tx_char_valid_i && tx_char_ready_o) |=> $stable(tx_disparity_o))
    else $error("encoder disparity moved without a character");

  a_enc_rd_unbal: assert property ( // [R10]
    s_tx_take ##0 ($countones(tx_in_code) != `CODEC_CG_ONES) |=>
      tx_disparity_o == ($past($countones(tx_in_code)) > `CODEC_CG_ONES
                         ? RD_POS : RD_NEG))
    else $error("encoder disparity wrong after unbalanced code-group");

  a_enc_rd_bal: assert property ( // [R7]
    s_tx_take ##0 ($countones(tx_6b) == `CODEC_6B_ONES &&
                   $countones(tx_4b) == `CODEC_4B_ONES &&
                   tx_6b != `CODEC_6B_POS_BAL && tx_6b != `CODEC_6B_NEG_BAL &&
                   tx_4b != `CODEC_4B_POS_BAL && tx_4b != `CODEC_4B_NEG_BAL)
      |=> $stable(tx_disparity_o))
    else $error("balanced code-group changed encoder disparity");

  a_enc_column: assert property ( // [R9]
    s_tx_take |-> (tx_disparity_o == RD_NEG
                   ? $countones(tx_in_code) >= `CODEC_CG_ONES
                   : $countones(tx_in_code) <= `CODEC_CG_ONES))
    else $error("encoder used the wrong column");

  a_enc_d07: assert property ( // [R16]
    s_tx_take ##0 (tx_byte_i == `CODEC_D07_BYTE && !tx_special_i) |->
      tx_in_code == (tx_disparity_o == RD_NEG ? `CODEC_D07_NEG
                                              : `CODEC_D07_POS))
    else $error("data 0x07 encoded wrongly");

  a_enc_d35: assert property ( // [R17]
    s_tx_take ##0 (tx_byte_i == `CODEC_D35_BYTE && !tx_special_i) |->
      tx_in_code == `CODEC_D35_CODE ##1 $stable(tx_disparity_o))
    else $error("data 0x23 encoded wrongly");

  a_tx_order: assert property ( // [R11]
    s_tx_take ##0 !tx_code_valid_o |=>
      tx_code_valid_o && tx_code_o == $past(tx_in_code))
    else $error("code-group not presented a cycle after its character");

  a_tx_no_loss: assert property ( // [R21]
    s_tx_stall |=> tx_code_valid_o && $stable(tx_code_o))
    else $error("stalled code-group dropped or changed");

  a_dec_d07: assert property ( // [R13]
    s_rx_take ##0 (rx_code_i == `CODEC_D07_NEG &&
                   rx_disparity_o == RD_NEG) |=>
      rx_char_valid_o && rx_byte_o == `CODEC_D07_BYTE &&
      !rx_special_o && !rx_invalid_o && rx_disparity_o == RD_POS)
    else $error("data 0x07 decoded wrongly");

  a_dec_wrong_col: assert property ( // [R14]
    s_rx_take ##0 (rx_code_i == `CODEC_D07_POS &&
                   rx_disparity_o == RD_NEG) |=> rx_invalid_o)
    else $error("code-group from the other column accepted");

  a_dec_bad_rd: assert property ( // [R22]
    s_rx_take ##0 (rx_code_i == '0) |=>
      rx_invalid_o && rx_disparity_o == RD_NEG)
    else $error("invalid code-group did not update disparity");

  a_dec_rd_hold: assert property ( // [R15]
    !rx_code_valid_i |=> $stable(rx_disparity_o) && !rx_char_valid_o)
    else $error("decoder state moved without a code-group");

endmodule

// [hdl/sub_block_disparity.sv]
// Purpose : ending disparity of one code-group sub-block
// Assumes : combinational, WIDTH is 6 or 4
// Notes   : balanced sub-blocks keep the incoming disparity unless they equal POS_PAT or NEG_PAT
`timescale 1ns/100ps
`include "codec_params.svh"

module sub_block_disparity #(
  parameter int unsigned      WIDTH   = 6,
  parameter logic [WIDTH-1:0] POS_PAT = `CODEC_6B_POS_BAL,
  parameter logic [WIDTH-1:0] NEG_PAT = `CODEC_6B_NEG_BAL
) (
  input  wire codec_pkg::rd_type rd_i,
  input  wire logic [WIDTH-1:0]  block_i,
  output codec_pkg::rd_type      rd_o
);
  import codec_pkg::*;

  // ========================================================================
  // disparity decision
  always_comb begin
    if ($countones(block_i) > WIDTH / 2) begin
      rd_o = RD_POS; // [R5]
    end else if ($countones(block_i) < WIDTH / 2) begin
      rd_o = RD_NEG; // [R6]
    end else if (block_i == POS_PAT) begin
      rd_o = RD_POS; // [R5]
    end else if (block_i == NEG_PAT) begin
      rd_o = RD_NEG; // [R6]
    end else begin
      rd_o = rd_i; // [R7]
    end
  end

endmodule

// [hdl/tx_skid_buffer.sv]
// Purpose : two-entry buffer with registered valid and ready
// Assumes : single clock, async active-high reset
// Notes   : output stage plus one skid entry; ready falls only when full
`timescale 1ns/100ps

module tx_skid_buffer #(
  parameter int unsigned WIDTH = 10
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);

  typedef struct packed {
    logic             out_valid;
    logic [WIDTH-1:0] out_data;
    logic             skid_valid;
    logic [WIDTH-1:0] skid_data;
    logic             in_ready;
  } buf_state_type;

  buf_state_type st_ff;
  buf_state_type nxt_st;

  // ==========================================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    if (out_ready_i || !st_ff.out_valid) begin
      if (st_ff.skid_valid) begin
        nxt_st.out_valid  = 1'b1;
        nxt_st.out_data   = st_ff.skid_data;
        nxt_st.skid_valid = 1'b0;
      end else begin
        nxt_st.out_valid = in_valid_i && st_ff.in_ready;
        nxt_st.out_data  = in_data_i;
      end
    end else if (in_valid_i && st_ff.in_ready) begin
      nxt_st.skid_valid = 1'b1;
      nxt_st.skid_data  = in_data_i;
    end
    nxt_st.in_ready = !nxt_st.skid_valid;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '{out_valid: 1'b0, out_data: '0, skid_valid: 1'b0,
                 skid_data: '0, in_ready: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign in_ready_o  = st_ff.in_ready;
  assign out_valid_o = st_ff.out_valid;
  assign out_data_o  = st_ff.out_data;

endmodule

// [testbench/serdes_model.sv]
// Purpose: serdes stand-in that serializes transmit code-groups
// Assumes: one bit per character clock, bit 9 of a code-group is bit a
// Notes  : stall_i holds ready low; each finished word lands in got
`timescale 1ns/100ps

module serdes_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       stall_i,
  input  wire logic       code_valid_i,
  input  wire logic [9:0] code_i,
  output logic            code_ready_o,
  output logic            serial_o
);
  logic [9:0] shift_ff;
  logic [9:0] word_ff;
  logic [3:0] left_ff;
  logic [9:0] got[$];

  // ======
  // word intake and shifter
  assign code_ready_o = !stall_i && left_ff == 4'h0;

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      left_ff  <= 4'h0;
      serial_o <= 1'h0;
    end else if (code_valid_i && code_ready_o) begin
      shift_ff <= code_i;
      left_ff  <= 4'hA;
    end else if (left_ff != 4'h0) begin
      serial_o <= shift_ff[9];
      shift_ff <= {shift_ff[8:0], 1'h0};
      word_ff  <= {word_ff[8:0], shift_ff[9]};
      left_ff  <= left_ff - 4'h1;
      if (left_ff == 4'h1) got.push_back({word_ff[8:0], shift_ff[9]});
    end else begin
      // idle line toggles so no stale bit stands
      serial_o <= ~serial_o;
    end
  end
endmodule

// [testbench/testbench.sv]
// Purpose: self-checking bench for the lane codec
// Assumes: expected code-groups come from a small hand table
// Notes  : a second instance starts its decoder positive
`timescale 1ns/100ps

module testbench;
  import codec_pkg::*;

  typedef struct {
    logic [7:0] b;
    logic       k;
    logic [9:0] neg;
    logic [9:0] pos;
  } ent_type;
  typedef struct {
    logic [9:0] c;
    logic [7:0] b;
    logic       k;
    logic       bad;
  } rx_ent_type;

  ent_type tab[5] = '{'{8'h07, 1'h0, 10'h38B, 10'h074},
                      '{8'h23, 1'h0, 10'h319, 10'h319},
                      '{8'h03, 1'h0, 10'h31B, 10'h314},
                      '{8'h00, 1'h0, 10'h274, 10'h18B},
                      '{8'h1C, 1'h1, 10'h0F4, 10'h30B}};
  rx_ent_type rx_tab[10] = '{'{10'h38B, 8'h07, 1'h0, 1'h0},
                            '{10'h074, 8'h07, 1'h0, 1'h0},
                            '{10'h319, 8'h23, 1'h0, 1'h0},
                            '{10'h3FF, 8'h00, 1'h0, 1'h1},
                            '{10'h074, 8'h07, 1'h0, 1'h0},
                            '{10'h0F4, 8'h1C, 1'h1, 1'h0},
                            '{10'h30B, 8'h00, 1'h0, 1'h1},
                            '{10'h30B, 8'h1C, 1'h1, 1'h0},
                            '{10'h000, 8'h00, 1'h0, 1'h1},
                            '{10'h074, 8'h00, 1'h0, 1'h1}};

  logic       clk_sys_i       = 1'h0;
  logic       rst_i           = 1'h1;
  logic       tx_char_valid_i = 1'h0;
  logic [7:0] tx_byte_i       = 8'h00;
  logic       tx_special_i    = 1'h0;
  logic       rx_code_valid_i = 1'h0;
  logic [9:0] rx_code_i       = 10'h000;
  logic       stall           = 1'h0;
  logic       tx_char_ready_o;
  logic       tx_code_valid_o;
  logic [9:0] tx_code_o;
  logic       tx_code_ready_i;
  rd_type     tx_disparity_o;
  logic       rx_char_valid_o;
  logic [7:0] rx_byte_o;
  logic       rx_special_o;
  logic       rx_invalid_o;
  rd_type     rx_disparity_o;
  logic       pos_invalid;
  rd_type     pos_rd;
  logic       serial;
  rd_type     tx_rd           = RD_NEG;
  rd_type     rx_rd           = RD_NEG;
  int         fail_count      = 0;
  int         comparisons     = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  lane_8b10b_codec DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .tx_char_valid_i(tx_char_valid_i), .tx_byte_i(tx_byte_i),
    .tx_special_i(tx_special_i), .tx_char_ready_o(tx_char_ready_o),
    .tx_code_valid_o(tx_code_valid_o), .tx_code_o(tx_code_o),
    .tx_code_ready_i(tx_code_ready_i), .tx_disparity_o(tx_disparity_o),
    .rx_code_valid_i(rx_code_valid_i), .rx_code_i(rx_code_i),
    .rx_char_valid_o(rx_char_valid_o), .rx_byte_o(rx_byte_o),
    .rx_special_o(rx_special_o), .rx_invalid_o(rx_invalid_o),
    .rx_disparity_o(rx_disparity_o));

  lane_8b10b_codec #(.RX_INIT_RD(RD_POS)) dut_pos (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .tx_char_valid_i(1'h0), .tx_byte_i(8'h00),
    .tx_special_i(1'h0), .tx_char_ready_o(), .tx_code_valid_o(),
    .tx_code_o(), .tx_code_ready_i(1'h0), .tx_disparity_o(),
    .rx_code_valid_i(rx_code_valid_i), .rx_code_i(rx_code_i),
    .rx_char_valid_o(), .rx_byte_o(), .rx_special_o(),
    .rx_invalid_o(pos_invalid), .rx_disparity_o(pos_rd));

  serdes_model partner (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .stall_i(stall), .code_valid_i(tx_code_valid_o), .code_i(tx_code_o),
    .code_ready_o(tx_code_ready_i), .serial_o(serial));

  // ======
  // helpers
  function automatic rd_type blk_rd(rd_type rd, logic [5:0] b, int w);
    int n = $countones(b);
    if (2 * n > w || (w == 6 && b == 6'h07) || (w == 4 && b == 6'h03))
      return RD_POS;
    if (2 * n < w || (w == 6 && b == 6'h38) || (w == 4 && b == 6'h0C))
      return RD_NEG;
    return rd;
  endfunction

  function automatic rd_type cg_rd(rd_type rd, logic [9:0] c);
    return blk_rd(blk_rd(rd, c[9:4], 6), {2'h0, c[3:0]}, 4);
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [9:0] seen, input logic [9:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic hang(input string what);
    fail_count++;
    $display("Error at %0t: %s timed out", $time, what);
    give_verdict();
  endtask

  task automatic offer(input int i);
    tx_char_valid_i = 1'h1;
    tx_byte_i       = tab[i].b;
    tx_special_i    = tab[i].k;
  endtask

  task automatic wait_take();
    int n;
    for (n = 0; n < 50 && tx_char_ready_o !== 1'h1; n++) step();
    if (n == 50) hang("char take");
    step();
  endtask

  // ======
  // scenarios
  task automatic test_reset_values();
    check(tx_disparity_o, RD_NEG, "tx start rd");
    check(rx_disparity_o, RD_NEG, "rx start rd");
    check(pos_rd, RD_POS, "second rx start rd");
    check(tx_code_valid_o, 1'h0, "idle code valid");
    $display("test reset_values done");
  endtask

  // hold: characters taken while the serdes stalls
  task automatic tx_seq(input int idx[$], input int hold);
    logic [9:0] e[$];
    int n;
    partner.got.delete();
    stall = hold > 0;
    foreach (idx[k]) begin
      e.push_back(tx_rd == RD_NEG ? tab[idx[k]].neg : tab[idx[k]].pos);
      tx_rd = cg_rd(tx_rd, e[k]);
    end
    foreach (idx[k]) begin
      offer(idx[k]);
      if (hold > 0 && k == hold) begin
        repeat (3) step();
        check(tx_char_ready_o, 1'h0, "full buffer ready");
        check(tx_code_valid_o, 1'h1, "stalled valid");
        check(tx_code_o, e[0], "stalled word held");
        stall = 1'h0;
      end
      wait_take();
    end
    tx_char_valid_i = 1'h0;
    for (n = 0; n < 300 && partner.got.size() < e.size(); n++) step();
    if (n == 300) hang("serdes drain");
    foreach (e[k]) check(partner.got[k], e[k], "tx code");
    check(tx_disparity_o, tx_rd, "tx rd");
  endtask

  task automatic test_tx_stream();
    tx_seq('{0, 0, 1, 2, 3, 4, 2}, 0);
    $display("test tx_stream done");
  endtask

  task automatic test_tx_stall();
    tx_seq('{4, 2, 4, 0}, 2);
    $display("test tx_stall done");
  endtask

  task automatic test_rx();
    foreach (rx_tab[k]) begin
      rx_code_valid_i = 1'h1;
      rx_code_i       = rx_tab[k].c;
      step();
      rx_rd = cg_rd(rx_rd, rx_tab[k].c);
      check(rx_char_valid_o, 1'h1, "rx pulse");
      check(rx_byte_o, rx_tab[k].b, "rx byte");
      check(rx_special_o, rx_tab[k].k, "rx special");
      check(rx_invalid_o, rx_tab[k].bad, "rx invalid");
      check(rx_disparity_o, rx_rd, "rx rd");
      if (k == 0) check(pos_invalid, 1'h1, "positive start");
    end
    rx_code_valid_i = 1'h0;
    step();
    check(rx_char_valid_o, 1'h0, "rx pulse ends");
    check(rx_disparity_o, rx_rd, "rx rd held");
    check(tx_disparity_o, tx_rd, "tx rd apart");
    $display("test rx done");
  endtask

  task automatic test_mid_reset();
    if (tx_rd == RD_NEG) begin
      offer(0);
      wait_take();
      tx_char_valid_i = 1'h0;
    end
    step();
    check(tx_disparity_o, RD_POS, "rd before reset");
    rst_i = 1'h1;
    #1;
    check(tx_disparity_o, RD_NEG, "rd in reset");
    check(tx_code_valid_o, 1'h0, "valid in reset");
    step();
    rst_i = 1'h0;
    tx_rd = RD_NEG;
    check(tx_char_ready_o, 1'h1, "ready after reset");
    check(pos_rd, RD_POS, "second rx rd after reset");
    tx_seq('{0}, 0);
    $display("test mid_reset done");
  endtask

  initial begin
    repeat (4) @(posedge clk_sys_i);
    #1;
    rst_i = 1'h0;
    test_reset_values();
    test_tx_stream();
    test_tx_stall();
    test_rx();
    test_mid_reset();
    give_verdict();
  end
endmodule
